// [hdl/mac_wake_pkg.sv]
// Package: register map, field positions and timing constants of the MAC wake block
package mac_wake_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_ADDR_LO = 12'h008;
  localparam logic [11:0] REG_ADDR_HI = 12'h00C;
  localparam logic [11:0] REG_WAKE_CRC0 = 12'h010;
  localparam logic [11:0] REG_STATS_RX = 12'h020;
  localparam logic [11:0] REG_STATS_ERR = 12'h024;
  localparam logic [11:0] REG_STATS_TX = 12'h028;
  localparam logic [11:0] REG_MGMT_CMD = 12'h030;
  localparam logic [11:0] REG_MGMT_DATA = 12'h034;
  // Control field positions
  localparam int CTRL_RGMII = 0;
  localparam int CTRL_PHY_ROLE = 1;
  localparam int CTRL_FULL_DUPLEX = 2;
  localparam int CTRL_SPEED_LO = 3;
  localparam int CTRL_MAGIC_EN = 5;
  localparam int CTRL_FRAME_EN = 6;
  localparam int CTRL_LINK_EN = 7;
  localparam int CTRL_WAKE_EN_LO = 8;
  // Status flag positions
  localparam int STAT_LINK = 0;
  localparam int STAT_FRAME = 1;
  localparam int STAT_MAGIC = 2;
  localparam int STAT_LINK_NOW = 3;
  localparam int STAT_MGMT_BUSY = 4;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h00000004;
  // Magic pattern figures and wake frame count
  localparam int MAGIC_SYNC_BYTES = 6;
  localparam int MAGIC_REPEATS = 16;
  localparam int WAKE_FRAMES = 4;
  // Frame length limits in bytes
  localparam int WAN_MAX_FRAME = 2000;
  localparam int LAN_MAX_FRAME = 9216;
  // Reference clock: 25 MHz from 100 MHz needs a toggle every 2 cycles
  localparam int CLK_MHZ = 100;
  localparam int REF_MHZ = 25;
  localparam int REF_HALF_CYCLES = CLK_MHZ / (2 * REF_MHZ);
  // Management clock divider half period in pclk cycles
  localparam int MDC_HALF_CYCLES = 20;
  // CRC-32 residue of a good frame, as held by the LSB-first shift register
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
endpackage : mac_wake_pkg

// [hdl/gigabit_mac_wake_logic.sv]
// Wake-on-LAN detector, receive checker, stats and PHY management master of one MAC port
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
module gigabit_mac_wake_logic #(
  parameter logic PORT_IS_LAN = 1'b0 // Port zero WAN, one LAN
) (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rx_clk, // Link receive clock, sampled
  input wire logic rx_dv, // Receive data valid
  input wire logic [7:0] rx_data, // Receive byte
  input wire logic rx_er, // Receive error from PHY
  input wire logic link_up, // Link state from PHY
  output logic rx_frame_ok, // Pulse: frame good, delivered
  output logic rx_frame_drop, // Pulse: frame dropped
  output logic [3:0] mode_out, // RGMII, PHY role, duplex, speed select
  output logic [1:0] speed_out, // Speed 00=10, 01=100, 10=1000
  output logic ref_clk_25, // 25 MHz reference to PHY
  output logic mdc, // Management clock
  output logic mdio_out, // Management data out
  output logic mdio_oe_n, // Management output enable, low drives
  input wire logic mdio_in, // Management data in
  output logic wake // Wake request to power management
);
  // Synchronisers for link-side signals
  logic [1:0] s_clk, s_dv, s_er, s_link, s_mdio;
  logic [7:0] s_d1, s_d2;
  logic clk_prev;
  logic link_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_clk <= 2'h0;
      s_dv <= 2'h0;
      s_er <= 2'h0;
      s_link <= 2'h0;
      s_mdio <= 2'h0;
      s_d1 <= 8'h00;
      s_d2 <= 8'h00;
    end else begin
      s_clk <= {s_clk[0], rx_clk};
      s_dv <= {s_dv[0], rx_dv};
      s_er <= {s_er[0], rx_er};
      s_link <= {s_link[0], link_up};
      s_mdio <= {s_mdio[0], mdio_in};
      s_d1 <= rx_data;
      s_d2 <= s_d1;
    end
  end

  // Edge finder; link clock at 160 ns gives ample pclk samples per half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      clk_prev <= s_clk[1];
      link_prev <= s_link[1];
    end
  end
  logic byte_stb;
  logic frame_end;
  logic in_frame;
  assign byte_stb = s_clk[1] & ~clk_prev & s_dv[1];
  assign frame_end = s_clk[1] & ~clk_prev & ~s_dv[1] & in_frame;

  // Registers
  logic [31:0] ctrl;
  logic [47:0] station;
  logic [31:0] wake_crc [mac_wake_pkg::WAKE_FRAMES];
  logic [2:0] wake_flags;
  logic [31:0] cnt_rx, cnt_err, cnt_tx;
  logic [15:0] mgmt_data;
  logic mgmt_busy;
  logic mgmt_start;
  logic [31:0] mgmt_cmd;
  logic apb_wr, apb_rd;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1; // Zero wait states
  assign mode_out = ctrl[3:0];
  assign speed_out = ctrl[mac_wake_pkg::CTRL_SPEED_LO +: 2];

  // Register writes
  // interface select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= mac_wake_pkg::CTRL_RESET;
      station <= 48'h000000000000;
      for (int i = 0; i < mac_wake_pkg::WAKE_FRAMES; i++) begin
        wake_crc[i] <= 32'h00000000;
      end
      mgmt_cmd <= 32'h00000000;
      mgmt_start <= 1'b0;
    end else begin
      mgmt_start <= 1'b0;
      if (apb_wr) begin
        unique case (paddr)
          mac_wake_pkg::REG_CTRL: ctrl <= pwdata;
          mac_wake_pkg::REG_ADDR_LO: station[31:0] <= pwdata;
          mac_wake_pkg::REG_ADDR_HI: station[47:32] <= pwdata[15:0];
          mac_wake_pkg::REG_MGMT_CMD: begin
            if (!mgmt_busy) begin
              mgmt_cmd <= pwdata;
              mgmt_start <= 1'b1;
            end
          end
          default: begin
            for (int i = 0; i < mac_wake_pkg::WAKE_FRAMES; i++) begin
              if (paddr == mac_wake_pkg::REG_WAKE_CRC0 + 12'(4 * i)) begin
                wake_crc[i] <= pwdata;
              end
            end
          end
        endcase
      end
    end
  end

  // Read mux; unmapped addresses answer with an error
  logic [31:0] next_rdata;
  logic hit;
  always_comb begin
    next_rdata = 32'h00000000;
    hit = 1'b1;
    unique case (paddr)
      mac_wake_pkg::REG_CTRL: next_rdata = ctrl;
      mac_wake_pkg::REG_STATUS: next_rdata = {27'h0000000, mgmt_busy, s_link[1], wake_flags};
      mac_wake_pkg::REG_ADDR_LO: next_rdata = station[31:0];
      mac_wake_pkg::REG_ADDR_HI: next_rdata = {16'h0000, station[47:32]};
      mac_wake_pkg::REG_STATS_RX: next_rdata = cnt_rx;
      mac_wake_pkg::REG_STATS_ERR: next_rdata = cnt_err;
      mac_wake_pkg::REG_STATS_TX: next_rdata = cnt_tx;
      mac_wake_pkg::REG_MGMT_CMD: next_rdata = mgmt_cmd;
      mac_wake_pkg::REG_MGMT_DATA: next_rdata = {16'h0000, mgmt_data};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < mac_wake_pkg::WAKE_FRAMES; i++) begin
          if (paddr == mac_wake_pkg::REG_WAKE_CRC0 + 12'(4 * i)) begin
            next_rdata = wake_crc[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  end
  assign prdata = next_rdata;
  assign pslverr = psel & penable & ~hit;

  // Receive CRC and length tracking
  logic [31:0] crc;
  logic [13:0] len;
  logic err_seen;
  logic [31:0] fcs_tail; // Last four bytes: the received check word at frame end
  logic [31:0] next_crc;
  always_comb begin
    next_crc = crc;
    for (int b = 0; b < 8; b++) begin
      next_crc = (next_crc >> 1) ^
        ((next_crc[0] ^ s_d2[b]) ? 32'hEDB88320 : 32'h00000000);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= 32'hFFFFFFFF;
      len <= 14'h0000;
      err_seen <= 1'b0;
      in_frame <= 1'b0;
      fcs_tail <= 32'h00000000;
    end else if (byte_stb) begin
      crc <= next_crc;
      // Check word goes out low byte first, so shift in from the top
      fcs_tail <= {s_d2, fcs_tail[31:8]};
      in_frame <= 1'b1;
      if (len != 14'h3FFF) begin
        len <= len + 14'h0001;
      end
      if (s_er[1]) begin
        err_seen <= 1'b1;
      end
    end else if (frame_end) begin
      crc <= 32'hFFFFFFFF;
      len <= 14'h0000;
      err_seen <= 1'b0;
      in_frame <= 1'b0;
    end
  end
  logic max_len_ok;
  logic frame_good;
  assign max_len_ok = PORT_IS_LAN ? (int'(len) <= mac_wake_pkg::LAN_MAX_FRAME)
                                  : (int'(len) <= mac_wake_pkg::WAN_MAX_FRAME);
  assign frame_good = (crc == mac_wake_pkg::CRC_RESIDUE) & ~err_seen & max_len_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame_ok <= 1'b0;
      rx_frame_drop <= 1'b0;
      cnt_rx <= 32'h00000000;
      cnt_err <= 32'h00000000;
      cnt_tx <= 32'h00000000;
    end else begin
      rx_frame_ok <= frame_end & frame_good;
      rx_frame_drop <= frame_end & ~frame_good;
      if (frame_end & frame_good) begin
        cnt_rx <= cnt_rx + 32'h00000001;
      end
      if (frame_end & ~frame_good) begin
        cnt_err <= cnt_err + 32'h00000001;
      end
    end
  end

  // Magic scanner: sync run count then address byte walk
  logic [2:0] ff_run;
  logic [2:0] byte_idx;
  logic [4:0] rep_cnt;
  logic armed;
  logic magic_seen;
  logic [7:0] want;
  assign want = station[8 * (5 - int'(byte_idx)) +: 8];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_run <= 3'h0;
      byte_idx <= 3'h0;
      rep_cnt <= 5'h00;
      armed <= 1'b0;
      magic_seen <= 1'b0;
    end else if (frame_end) begin
      ff_run <= 3'h0;
      byte_idx <= 3'h0;
      rep_cnt <= 5'h00;
      armed <= 1'b0;
      magic_seen <= 1'b0;
    end else if (byte_stb) begin
      if (s_d2 == 8'hFF) begin
        if (ff_run != 3'(mac_wake_pkg::MAGIC_SYNC_BYTES)) begin
          ff_run <= ff_run + 3'h1;
        end
      end else begin
        ff_run <= 3'h0;
      end
      if (armed && s_d2 == want) begin
        if (byte_idx == 3'h5) begin
          byte_idx <= 3'h0;
          rep_cnt <= rep_cnt + 5'h01;
          if (rep_cnt == 5'(mac_wake_pkg::MAGIC_REPEATS - 1)) begin
            magic_seen <= 1'b1;
            armed <= 1'b0;
          end
        end else begin
          byte_idx <= byte_idx + 3'h1;
        end
      end else begin
        // A broken sequence restarts; a long 0xFF run keeps us ready
        byte_idx <= 3'h0;
        rep_cnt <= 5'h00;
        armed <= (ff_run == 3'(mac_wake_pkg::MAGIC_SYNC_BYTES)) ||
                 (s_d2 == 8'hFF && ff_run == 3'(mac_wake_pkg::MAGIC_SYNC_BYTES - 1));
      end
    end
  end

  // wake frame by CRC match
  // Running register is the fixed residue for any good frame, so match the check word
  logic crc_match;
  always_comb begin
    crc_match = 1'b0;
    for (int i = 0; i < mac_wake_pkg::WAKE_FRAMES; i++) begin
      if (ctrl[mac_wake_pkg::CTRL_WAKE_EN_LO + i] && wake_crc[i] == fcs_tail) begin
        crc_match = 1'b1;
      end
    end
  end

  logic [2:0] ev;
  assign ev[mac_wake_pkg::STAT_LINK] = ctrl[mac_wake_pkg::CTRL_LINK_EN] & (s_link[1] ^ link_prev);
  assign ev[mac_wake_pkg::STAT_FRAME] = ctrl[mac_wake_pkg::CTRL_FRAME_EN] & frame_end &
                                        frame_good & crc_match;
  assign ev[mac_wake_pkg::STAT_MAGIC] = ctrl[mac_wake_pkg::CTRL_MAGIC_EN] & frame_end &
                                        frame_good & magic_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ev[i]) begin
          wake_flags[i] <= 1'b1;
        end else if (apb_wr && paddr == mac_wake_pkg::REG_STATUS && pwdata[i]) begin
          wake_flags[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake <= 1'b0;
    end else begin
      wake <= |(wake_flags & {ctrl[mac_wake_pkg::CTRL_MAGIC_EN],
                              ctrl[mac_wake_pkg::CTRL_FRAME_EN],
                              ctrl[mac_wake_pkg::CTRL_LINK_EN]});
    end
  end

  logic [1:0] ref_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 2'h0;
      ref_clk_25 <= 1'b0;
    end else if (ref_cnt == 2'(mac_wake_pkg::REF_HALF_CYCLES - 1)) begin
      ref_cnt <= 2'h0;
      ref_clk_25 <= ~ref_clk_25;
    end else begin
      ref_cnt <= ref_cnt + 2'h1;
    end
  end

  // management frame shifter; cmd: [31]=read, [30:26]=phy, [25:21]=reg, [15:0]=data
  logic [4:0] mdc_cnt;
  logic mdc_rise_en;
  logic [6:0] bit_cnt;
  logic [63:0] shift;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdc_cnt <= 5'h00;
      mdc <= 1'b0;
      mdc_rise_en <= 1'b0;
    end else begin
      mdc_rise_en <= 1'b0;
      if (mdc_cnt == 5'(mac_wake_pkg::MDC_HALF_CYCLES - 1)) begin
        mdc_cnt <= 5'h00;
        mdc <= ~mdc & mgmt_busy;
        mdc_rise_en <= ~mdc & mgmt_busy;
      end else begin
        mdc_cnt <= mdc_cnt + 5'h01;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_busy <= 1'b0;
      bit_cnt <= 7'h00;
      shift <= 64'h0000000000000000;
      mgmt_data <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (mgmt_start) begin
      // Preamble, start 01, opcode, addresses, turnaround, data
      mgmt_busy <= 1'b1;
      bit_cnt <= 7'h00;
      shift <= {32'hFFFFFFFF, 2'b01, mgmt_cmd[31] ? 2'b10 : 2'b01,
                mgmt_cmd[30:21], 2'b10, mgmt_cmd[15:0]};
    end else if (mgmt_busy && mdc_rise_en) begin
      // Data changes after MDC rises; read bits sampled on the same edge
      mdio_out <= shift[63];
      mdio_oe_n <= mgmt_cmd[31] && bit_cnt >= 7'd46;
      shift <= {shift[62:0], 1'b0};
      if (mgmt_cmd[31] && bit_cnt >= 7'd48) begin
        mgmt_data <= {mgmt_data[14:0], s_mdio[1]};
      end
      bit_cnt <= bit_cnt + 7'h01;
      if (bit_cnt == 7'd64) begin
        mgmt_busy <= 1'b0;
        mdio_oe_n <= 1'b1;
      end
    end
  end
  // datapath stages live outside this block
endmodule : gigabit_mac_wake_logic

// [testbench/gigabit_mac_wake_logic_asserts.sv]
// Port checker for the MAC wake block
`timescale 1ns/10ps
module mac_wake_asserts (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic rx_dv, // Receive data valid
  input wire logic rx_frame_ok, // Good frame pulse
  input wire logic rx_frame_drop, // Dropped frame pulse
  input wire logic [3:0] mode_out, // Mode select
  input wire logic [1:0] speed_out, // Speed select
  input wire logic ref_clk_25, // Reference clock
  input wire logic wake // Wake request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic hit;
  // Access phase and decoded map; gaps at 0x02C and 0x038 upwards
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0 &&
    !(paddr inside {12'h02C, 12'h038, 12'h03C});
  ready_now_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  map_err_a: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped access");
  map_ok_a: assert property ((acc && hit) || !acc |-> !pslverr)
    else $error("error on mapped or idle cycle");
  mode_set_a: assert property (wr && paddr == 12'h000 |=>
    32'({speed_out, mode_out[2:0]}) == ($past(pwdata) & 32'h1F))
    else $error("mode outputs not from control write");
  ref_hi_a: assert property ($rose(ref_clk_25) |=> ref_clk_25 ##1 !ref_clk_25)
    else $error("reference high phase wrong");
  ref_lo_a: assert property ($fell(ref_clk_25) |=> !ref_clk_25 ##1 ref_clk_25)
    else $error("reference low phase wrong");
  pulse_one_a: assert property (rx_frame_ok || rx_frame_drop |=>
    !(rx_frame_ok || rx_frame_drop) && !$past(rx_frame_ok && rx_frame_drop))
    else $error("frame result pulse too long or both");
  frame_end_a: assert property (rx_frame_ok || rx_frame_drop |-> !rx_dv)
    else $error("frame result while data valid");
  wake_fall_a: assert property ($fell(wake) |-> $past(wr) || $past(wr, 2))
    else $error("wake dropped without write");
  cover property ($rose(wake));
  cover property (rx_frame_drop);
  cover property (acc && !hit);
endmodule : mac_wake_asserts
bind gigabit_mac_wake_logic mac_wake_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .rx_dv, .rx_frame_ok, .rx_frame_drop,
  .mode_out, .speed_out, .ref_clk_25, .wake);

// [testbench/phy_model.sv]
// Behavioural PHY model driving the receive side of the link
`timescale 1ns/10ps
module phy_model (
  output logic rx_clk, // Receive clock, still between frames
  output logic rx_dv, // Receive data valid
  output logic [7:0] rx_data, // Receive byte
  output logic rx_er, // Receive error
  output logic link_up // Link state
);
  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rx_data = 8'h00;
    rx_er = 1'b0;
    link_up = 1'b0;
  end
  function automatic logic [31:0] fcs(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) for (int k = 0; k < 8; k++) c = (c[0] ^ q[i][k]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    return ~c;
  endfunction : fcs
  // One byte per clock; data moves while the clock is low
  task automatic clk_byte(input logic [7:0] b, input logic dv, input logic er);
    rx_data = b;
    rx_dv = dv;
    rx_er = er;
    #80 rx_clk = 1'b1;
    #80 rx_clk = 1'b0;
  endtask : clk_byte
  // byte-wide frame; mode 1 corrupts the check, mode 2 flags an error
  task automatic send(input logic [7:0] q[$], input int mode);
    logic [31:0] f;
    #3;
    f = fcs(q) ^ (mode == 1 ? 32'h1 : 32'h0);
    for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
    foreach (q[i]) clk_byte(q[i], 1'b1, mode == 2 && i == 10);
    // Released data first inverts the last byte, then repeats it
    clk_byte(~q[$], 1'b0, 1'b0);
    clk_byte(q[$], 1'b0, 1'b0);
  endtask : send
  task automatic set_link(input logic v);
    #3 link_up = v;
  endtask : set_link
endmodule : phy_model

// [testbench/tb.sv]
// Self-checking testbench for the MAC wake block
`timescale 1ns/10ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_clk, rx_dv, rx_er, link_up, rx_frame_ok, rx_frame_drop;
  logic [7:0] rx_data;
  logic [3:0] mode_out;
  logic [1:0] speed_out;
  logic ref_clk_25, mdc, mdio_out, mdio_oe_n, mdio_in, wake;
  logic [7:0] q[$];
  int n_errors = 0;
  int checked = 0;
  int n_ok = 0;
  int n_drop = 0;
  int cycles = 0;
  int n_mbits = 0;
  logic mdc_q;
  logic [63:0] mbits;
  assign mdio_in = mdio_oe_n ? 1'b1 : mdio_out;
  gigabit_mac_wake_logic #(.PORT_IS_LAN(1'b0)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_clk, .rx_dv, .rx_data,
    .rx_er, .link_up, .rx_frame_ok, .rx_frame_drop, .mode_out, .speed_out, .ref_clk_25,
    .mdc, .mdio_out, .mdio_oe_n, .mdio_in, .wake);
  phy_model phy (.rx_clk, .rx_dv, .rx_data, .rx_er, .link_up);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Frame result counts and hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (rx_frame_ok === 1'b1) n_ok <= n_ok + 1;
    if (rx_frame_drop === 1'b1) n_drop <= n_drop + 1;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end
  // Management line: a driven bit is taken at each falling MDC
  always @(posedge pclk) begin
    mdc_q <= mdc;
    if (mdc_q === 1'b1 && mdc === 1'b0 && mdio_oe_n === 1'b0) begin
      mbits <= {mbits[62:0], mdio_out};
      n_mbits <= n_mbits + 1;
    end
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  // Setup then access; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Broadcast header, sync run, then address repeats
  task automatic mk_magic(input int reps);
    q = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    repeat (6) q.push_back(8'hFF);
    repeat (reps) q = {q, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
  endtask : mk_magic
  // Send a frame, check the sticky flags and wake, then clear them
  task automatic rx(input int mode, input logic [2:0] f);
    phy.send(q, mode);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk({29'h0, f}, {29'h0, rd[2:0]}); // flags
    chk({31'h0, f != 3'h0}, {31'h0, wake}); // wake level
    apb(1'b1, 12'h004, 32'h7);
    repeat (3) @(posedge pclk);
    chk(32'h0, {31'h0, wake}); // cleared
  endtask : rx
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(mac_wake_pkg::CTRL_RESET, rd); // control reset
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h0, rd & 32'h1F); // flags clear
    apb(1'b0, 12'h040, 32'h0);
    chk(32'h1, {31'h0, err}); // unmapped refused
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode;
    logic [31:0] tbl[3];
    tbl = '{32'h1F, 32'h0A, 32'h11};
    foreach (tbl[i]) begin
      apb(1'b1, 12'h000, tbl[i]);
      apb(1'b0, 12'h000, 32'h0);
      chk(tbl[i], rd); // control readback
      chk(tbl[i] & 32'hF, {28'h0, mode_out}); // mode pins
      chk((tbl[i] >> 3) & 32'h3, {30'h0, speed_out}); // speed pins
    end
    $display("test mode done");
  endtask : t_mode
  task automatic t_magic;
    apb(1'b1, 12'h00C, 32'h0000A1B2);
    apb(1'b1, 12'h008, 32'hC3D4E5F6);
    apb(1'b1, 12'h000, 32'h24);
    mk_magic(16);
    rx(0, 3'h4); // pattern wakes
    mk_magic(15);
    rx(0, 3'h0); // short pattern ignored
    mk_magic(16);
    rx(1, 3'h0); // bad check dropped
    mk_magic(16);
    rx(2, 3'h0); // receive error dropped
    apb(1'b1, 12'h000, 32'h04);
    mk_magic(16);
    rx(0, 3'h0); // detection disabled
    $display("test magic done");
  endtask : t_magic
  task automatic t_link;
    apb(1'b1, 12'h000, 32'h84);
    phy.set_link(1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h9, rd & 32'hF); // link up flag
    chk(32'h1, {31'h0, wake}); // wake level
    apb(1'b1, 12'h004, 32'h1);
    phy.set_link(1'b0);
    repeat (8) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h1, rd & 32'hF); // link down flag
    apb(1'b1, 12'h004, 32'h1);
    $display("test link done");
  endtask : t_link
  task automatic t_wakef;
    q = {};
    for (int i = 0; i < 64; i++) q.push_back(8'(i));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h010 + 12'(4 * i), phy.fcs(q));
      apb(1'b1, 12'h000, 32'h44 | (32'h100 << i));
      rx(0, 3'h2); // each definition
    end
    q[0] = 8'h55;
    rx(0, 3'h0); // other check value
    $display("test wake frame done");
  endtask : t_wakef
  task automatic t_stats;
    apb(1'b0, 12'h020, 32'h0);
    chk(32'h8, rd); // good frames
    apb(1'b0, 12'h024, 32'h0);
    chk(32'h2, rd); // errored frames
    chk(32'h8, 32'(n_ok)); // good pulses
    chk(32'h2, 32'(n_drop)); // drop pulses
    $display("test stats done");
  endtask : t_stats
  // Poll the busy flag until the management frame is over
  task automatic mgmt_wait;
    apb(1'b0, 12'h004, 32'h0);
    for (int i = 0; i < 1500 && rd[4] !== 1'b0; i++) apb(1'b0, 12'h004, 32'h0);
    chk(32'h0, {31'h0, rd[4]}); // done
  endtask : mgmt_wait
  task automatic t_mgmt;
    int base;
    base = n_mbits;
    apb(1'b1, 12'h030, 32'h0E20BEEF);
    apb(1'b1, 12'h030, 32'h84400000);
    apb(1'b0, 12'h030, 32'h0);
    chk(32'h0E20BEEF, rd); // command refused while busy
    mgmt_wait();
    chk(32'h40, 32'(n_mbits - base)); // write frame length
    chk(32'hFFFFFFFF, mbits[63:32]); // write preamble
    chk({2'b01, 2'b01, 5'h03, 5'h11, 2'b10, 16'hBEEF}, mbits[31:0]); // write frame
    base = n_mbits;
    apb(1'b1, 12'h030, 32'h84400000);
    apb(1'b0, 12'h004, 32'h0);
    chk(32'h1, {31'h0, rd[4]}); // busy
    mgmt_wait();
    chk(32'h2E, 32'(n_mbits - base)); // read releases line
    apb(1'b0, 12'h034, 32'h0);
    chk(32'hFFFF, rd & 32'hFFFF); // idle line reads ones
    $display("test management done");
  endtask : t_mgmt
  task automatic results;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_magic();
    t_link();
    t_wakef();
    t_stats();
    t_mgmt();
    results();
  end
endmodule : tb
